/* src/lst_map.svh */
`ifndef LST_MAP_SVH
`define LST_MAP_SVH
// register indices (byte address is four times the index)
`define LST_IDX_TIMER_B      8'h0D
`define LST_IDX_SHUTDOWN     8'h10
`define LST_IDX_SEL_LOW      8'h14
`define LST_IDX_SEL_HIGH     8'h15
// field positions and masks
`define LST_TIMER_MASK       8'h77
`define LST_SHUTDOWN_MASK    8'h70
`define LST_SEL_MASK         8'h77
`define LST_SD_RESTART_KEEP  8'h70
`define LST_SD_OV_BIT        6
`define LST_SD_UV_BIT        5
`define LST_SD_REC_BIT       4
`define LST_RESET_VALUE      8'h00
// timing in microseconds and cycles per microsecond at 200 MHz
`define LST_CLK_MHZ          200
`define LST_US_PER_MS        1000
`endif

/* src/lst_pkg.sv */
package lst_pkg;
   typedef enum logic [2:0] {
      LST_SEL_OFF, LST_SEL_ON, LST_SEL_TMR_A, LST_SEL_TMR_B,
      LST_SEL_PWM_A, LST_SEL_PWM_B, LST_SEL_RSV6, LST_SEL_RSV7
   } lst_sel_e;
   typedef enum logic [1:0] {LST_T_IDLE, LST_T_ON, LST_T_OFF} lst_tstate_e;
endpackage

/* src/lst_tmr_if.sv */
`timescale 1ns/100ps
// timer settings and its output between top and timer
interface lst_tmr_if;
   logic [2:0] on_code;
   logic [2:0] per_code;
   logic       restart;
   logic       out;
   modport ctrl (output on_code, output per_code, output restart,
                 input out);
   modport tmr  (input on_code, input per_code, input restart,
                 output out);
endinterface

/* src/lst_timer.sv */
`timescale 1ns/100ps
`include "lst_map.svh"
// cyclic on/off timer, second timer of the block
module lst_timer
   import lst_pkg::*;
#(
   parameter int SCALE = 1
)(
   input  wire logic clk,
   input  wire logic rst_n,
   lst_tmr_if.tmr    tif
);
   localparam int CPU = `LST_CLK_MHZ / SCALE; // cycles per microsecond
   localparam int W = 32;

   lst_tstate_e st_r, st_nxt;
   logic [W-1:0] cnt_r, cnt_nxt;
   logic [W-1:0] on_cyc, per_cyc;
   logic         out_r, out_nxt;

   // on-time in cycles, zero for non-running codes
   function automatic logic [W-1:0] on_cycles(input logic [2:0] c);
      unique case (c)
         3'h1: on_cycles = W'(100 * CPU);
         3'h2: on_cycles = W'(300 * CPU);
         3'h3: on_cycles = W'(1000 * CPU);
         3'h4: on_cycles = W'(10 * `LST_US_PER_MS * CPU);
         3'h5: on_cycles = W'(20 * `LST_US_PER_MS * CPU);
         default: on_cycles = '0;
      endcase
   endfunction

   // period in cycles, zero for the reserved code
   function automatic logic [W-1:0] per_cycles(input logic [2:0] c);
      unique case (c)
         3'h0: per_cycles = W'(10 * `LST_US_PER_MS * CPU);
         3'h1: per_cycles = W'(20 * `LST_US_PER_MS * CPU);
         3'h2: per_cycles = W'(50 * `LST_US_PER_MS * CPU);
         3'h3: per_cycles = W'(100 * `LST_US_PER_MS * CPU);
         3'h4: per_cycles = W'(200 * `LST_US_PER_MS * CPU);
         3'h5: per_cycles = W'(1000 * `LST_US_PER_MS * CPU);
         3'h6: per_cycles = W'(2000 * `LST_US_PER_MS * CPU);
         default: per_cycles = '0;
      endcase
   endfunction

   assign on_cyc  = on_cycles(tif.on_code);
   assign per_cyc = per_cycles(tif.per_code);
   assign tif.out = out_r;

   // period sequencing
   always_comb
   begin
      st_nxt  = st_r;
      cnt_nxt = cnt_r + W'(1);
      out_nxt = 1'b0;
      if (tif.restart || on_cyc == '0 || per_cyc == '0)
      begin
         st_nxt  = LST_T_IDLE;
         cnt_nxt = '0;
         out_nxt = (tif.on_code == 3'h6) && !tif.restart;
      end
      else
      begin
         unique case (st_r)
            LST_T_IDLE:
            begin
               st_nxt  = LST_T_ON;
               cnt_nxt = W'(1);
               out_nxt = 1'b1;
            end
            LST_T_ON:
            begin
               out_nxt = 1'b1;
               if (cnt_r >= on_cyc)
               begin
                  st_nxt  = LST_T_OFF;
                  out_nxt = 1'b0;
               end
            end
            LST_T_OFF:
            begin
               if (cnt_r >= per_cyc)
               begin
                  st_nxt  = LST_T_ON;
                  cnt_nxt = W'(1);
                  out_nxt = 1'b1;
               end
            end
            default:
            begin
               st_nxt = LST_T_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         st_r  <= LST_T_IDLE;
         cnt_r <= '0;
         out_r <= 1'b0;
      end
      else
      begin
         st_r  <= st_nxt;
         cnt_r <= cnt_nxt;
         out_r <= out_nxt;
      end
   end
endmodule

/* src/lst_switch_mux.sv */
`timescale 1ns/100ps
// per-switch source selection
module lst_switch_mux
   import lst_pkg::*;
#(
   parameter int N = 4
)(
   input  wire logic [3*N-1:0] sel,
   input  wire logic           tmr_a,
   input  wire logic           tmr_b,
   input  wire logic           pwm_a,
   input  wire logic           pwm_b,
   output logic      [N-1:0]   drive
);
   // decode each select field
   always_comb
   begin
      for (int i = 0; i < N; i++)
      begin
         unique case (lst_sel_e'(sel[3*i +: 3]))
            LST_SEL_OFF:   drive[i] = 1'b0;
            LST_SEL_ON:    drive[i] = 1'b1;
            LST_SEL_TMR_A: drive[i] = tmr_a;
            LST_SEL_TMR_B: drive[i] = tmr_b;
            LST_SEL_PWM_A: drive[i] = pwm_a;
            LST_SEL_PWM_B: drive[i] = pwm_b;
            default:       drive[i] = 1'b0;
         endcase
      end
   end
endmodule

/* src/lst_top.sv */
// Functional notes
// - on-time codes 1..5 give 0.1/0.3/1/10/20 ms; 0 stops, output low
// - on-time code 6 stops timer, output high; 7 reserved
// - period codes 0..6 give 10,20,50,100,200 ms,1 s,2 s; 7 reserved
// - timer assigned first, starts itself when a running on-time is set
// - restart clear of switches with cyclic sense also clears timer; code clears timer on every restart entry
// - reserved bits read zero and ignore writes
// - bit 6 zero: supply overvoltage turns all switches off
// - bit 5 zero: supply undervoltage turns all switches off
// - bit 4 one: switches return to prior state after fault ends
// - switch fields at bits 2:0 and 6:4 of two select registers
// - overcurrent or overtemperature clears that switch's select code
// - shutdown register zero on resets; restart keeps bits 6:4
// - timer and select registers zero on resets and restart entry
//
// Decided for this implementation: the APB slave port.
`timescale 1ns/100ps
`include "lst_map.svh"
module lst_top
   import lst_pkg::*;
#(
   parameter int TIME_SCALE = 1
)(
   input  wire logic        clk,
   input  wire logic        rst_n,
   input  wire logic        soft_reset,
   input  wire logic        restart_entry,
   input  wire logic        cyclic_sense,
   input  wire logic        supply_ov,
   input  wire logic        supply_uv,
   input  wire logic [3:0]  switch_fault,
   input  wire logic        first_timer,
   input  wire logic        first_pwm,
   input  wire logic        second_pwm,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   output logic      [3:0]  switch_output
);
   logic [7:0]  tmr_r, tmr_nxt;
   logic [7:0]  sd_r, sd_nxt;
   logic [7:0]  sel_lo_r, sel_lo_nxt;
   logic [7:0]  sel_hi_r, sel_hi_nxt;
   logic [31:0] rd_r, rd_nxt;
   logic        ack_r, ack_nxt;
   logic [3:0]  saved_r, saved_nxt;
   logic        cut_r, cut_nxt;
   logic [3:0]  out_r, out_nxt;
   logic [3:0]  drive;
   logic        wr, rd, hit;
   logic [7:0]  idx;
   logic        ov_cut, uv_cut, fault_now;
   logic [11:0] sel_all;

   lst_tmr_if tif ();

   // APB decode: word aligned index
   assign idx = {2'h0, paddr[7:2]};
   // writes land at the ready edge, reads are captured one cycle before it
   assign wr  = psel && penable && pwrite && ack_r;
   assign rd  = psel && penable && !pwrite && !ack_r;

   function automatic logic mapped(input logic [7:0] i,
                                   input logic [11:0] a);
      mapped = (a[11:8] == 4'h0) && (a[1:0] == 2'h0) &&
               (i == `LST_IDX_TIMER_B || i == `LST_IDX_SHUTDOWN ||
                i == `LST_IDX_SEL_LOW || i == `LST_IDX_SEL_HIGH);
   endfunction

   assign hit     = mapped(idx, paddr);
   // one wait state so the registered read data stands with ready
   assign pready  = ack_r;
   assign pslverr = psel && penable && ack_r && !hit;
   assign prdata  = rd_r;

   // supply fault cutoff terms
   assign ov_cut    = supply_ov && !sd_r[`LST_SD_OV_BIT];
   assign uv_cut    = supply_uv && !sd_r[`LST_SD_UV_BIT];
   assign fault_now = ov_cut || uv_cut;

   // timer b settings
   assign tif.on_code  = tmr_r[6:4];
   assign tif.per_code = tmr_r[2:0];
   assign tif.restart  = restart_entry || soft_reset;

   lst_timer #(
      .SCALE (TIME_SCALE)
   ) u_tmr (
      .clk   (clk),
      .rst_n (rst_n),
      .tif   (tif)
   );

   assign sel_all = {sel_hi_r[6:4], sel_hi_r[2:0],
                     sel_lo_r[6:4], sel_lo_r[2:0]};

   lst_switch_mux #(
      .N (4)
   ) u_mux (
      .sel   (sel_all),
      .tmr_a (first_timer),
      .tmr_b (tif.out),
      .pwm_a (first_pwm),
      .pwm_b (second_pwm),
      .drive (drive)
   );

   // register file next state
   always_comb
   begin
      tmr_nxt    = tmr_r;
      sd_nxt     = sd_r;
      sel_lo_nxt = sel_lo_r;
      sel_hi_nxt = sel_hi_r;
      if (wr && hit)
      begin
         unique case (idx)
            `LST_IDX_TIMER_B:  tmr_nxt = pwdata[7:0] & `LST_TIMER_MASK;
            `LST_IDX_SHUTDOWN: sd_nxt = pwdata[7:0] & `LST_SHUTDOWN_MASK;
            `LST_IDX_SEL_LOW:  sel_lo_nxt = pwdata[7:0] & `LST_SEL_MASK;
            default:           sel_hi_nxt = pwdata[7:0] & `LST_SEL_MASK;
         endcase
      end
      // hardware clear on switch fault wins over a write
      if (switch_fault[0]) sel_lo_nxt[2:0] = 3'h0;
      if (switch_fault[1]) sel_lo_nxt[6:4] = 3'h0;
      if (switch_fault[2]) sel_hi_nxt[2:0] = 3'h0;
      if (switch_fault[3]) sel_hi_nxt[6:4] = 3'h0;
      if (soft_reset)
      begin
         tmr_nxt    = `LST_RESET_VALUE;
         sd_nxt     = `LST_RESET_VALUE;
         sel_lo_nxt = `LST_RESET_VALUE;
         sel_hi_nxt = `LST_RESET_VALUE;
      end
      else if (restart_entry)
      begin
         sd_nxt     = sd_r & `LST_SD_RESTART_KEEP;
         sel_lo_nxt = `LST_RESET_VALUE;
         sel_hi_nxt = `LST_RESET_VALUE;
         tmr_nxt    = `LST_RESET_VALUE;
         if (cyclic_sense)
            tmr_nxt = `LST_RESET_VALUE;
      end
   end

   // read data and handshake next state
   always_comb
   begin
      rd_nxt  = rd_r;
      ack_nxt = psel && penable && !ack_r;  // ready one cycle into access
      if (rd)
      begin
         rd_nxt = 32'h0000_0000;            // unmapped reads return zero
         if (hit)
         begin
            unique case (idx)
               `LST_IDX_TIMER_B:  rd_nxt = {24'h000000, tmr_r};
               `LST_IDX_SHUTDOWN: rd_nxt = {24'h000000, sd_r};
               `LST_IDX_SEL_LOW:  rd_nxt = {24'h000000, sel_lo_r};
               default:           rd_nxt = {24'h000000, sel_hi_r};
            endcase
         end
      end
   end

   // supply fault cutoff and recovery
   always_comb
   begin
      cut_nxt   = fault_now;
      saved_nxt = saved_r;
      if (fault_now && !cut_r)
         saved_nxt = drive;               // state before the fault
      out_nxt = drive;
      if (fault_now)
         out_nxt = 4'h0;
      else if (cut_r && !sd_r[`LST_SD_REC_BIT])
      begin
         cut_nxt = 1'b1;                  // stay off until reprogrammed
         out_nxt = 4'h0;
         if (wr && hit)
            cut_nxt = 1'b0;
      end
      else if (cut_r)
         out_nxt = saved_r;               // restore prior state
      if (soft_reset || restart_entry)
      begin
         cut_nxt = 1'b0;
         out_nxt = 4'h0;
      end
   end

   assign switch_output = out_r;

   // configuration registers
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         tmr_r    <= `LST_RESET_VALUE;
         sd_r     <= `LST_RESET_VALUE;
         sel_lo_r <= `LST_RESET_VALUE;
         sel_hi_r <= `LST_RESET_VALUE;
      end
      else
      begin
         tmr_r    <= tmr_nxt;
         sd_r     <= sd_nxt;
         sel_lo_r <= sel_lo_nxt;
         sel_hi_r <= sel_hi_nxt;
      end
   end

   // read data and handshake state
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         rd_r  <= 32'h0000_0000;
         ack_r <= 1'b0;
      end
      else
      begin
         rd_r  <= rd_nxt;
         ack_r <= ack_nxt;
      end
   end

   // cutoff state and registered switch drive
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         saved_r <= 4'h0;
         cut_r   <= 1'b0;
         out_r   <= 4'h0;
      end
      else
      begin
         saved_r <= saved_nxt;
         cut_r   <= cut_nxt;
         out_r   <= out_nxt;
      end
   end
endmodule

/* dv/lst_props.sv */
`timescale 1ns/100ps
// port-level checks of the switch block
module lst_props
(
   input wire logic        clk,
   input wire logic        rst_n,
   input wire logic        soft_reset,
   input wire logic        restart_entry,
   input wire logic        supply_ov,
   input wire logic        supply_uv,
   input wire logic [3:0]  switch_fault,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic        pready,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic [3:0]  switch_output
);
   logic [2:0] sd_r;
   logic [2:0] sd_nxt;
   // shadow of shutdown bits 6:4
   always_comb
   begin
      sd_nxt = sd_r;
      if (psel && penable && pready && pwrite && paddr == 12'h040)
         sd_nxt = pwdata[6:4];
      if (soft_reset)
         sd_nxt = 3'h0;
   end
   always_ff @(posedge clk)
   begin
      if (!rst_n)
         sd_r <= 3'h0;
      else
         sd_r <= sd_nxt;
   end
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   sequence s_rd_sd;
      psel && penable && pready && !pwrite && paddr == 12'h040;
   endsequence
   sequence s_ov;
      (supply_ov && !sd_r[2])[*3];
   endsequence
   sequence s_uv;
      (supply_uv && !sd_r[1])[*3];
   endsequence
   chk_rsv_upper: assert property (prdata[31:7] == 25'h0)
      else $error("upper read bits set");
   chk_sd_readback: assert property (s_rd_sd |->
      prdata == {25'h0, sd_r, 4'h0}) else $error("shutdown read");
   chk_ov_cut: assert property (s_ov |=> switch_output == 4'h0)
      else $error("overvoltage cutoff missing");
   chk_uv_cut: assert property (s_uv |=> switch_output == 4'h0)
      else $error("undervoltage cutoff missing");
   chk_fault_one: assert property (switch_fault[0][*3] |=>
      !switch_output[0]) else $error("switch one fault");
   chk_fault_four: assert property (switch_fault[3][*3] |=>
      !switch_output[3]) else $error("switch four fault");
   chk_soft_clear: assert property (soft_reset[*3] |=>
      switch_output == 4'h0) else $error("soft reset output");
   chk_restart_clear: assert property (restart_entry[*3] |=>
      switch_output == 4'h0) else $error("restart output");
endmodule
bind lst_top lst_props u_props (.clk, .rst_n, .soft_reset, .restart_entry,
   .supply_ov, .supply_uv, .switch_fault, .psel, .penable, .pwrite,
   .pready, .paddr, .pwdata, .prdata, .switch_output);

/* dv/tb_top.sv */
`timescale 1ns/100ps
`include "lst_map.svh"
// register-level bench of the switch block
module tb_top;
   localparam logic [11:0] A_TMR = {2'b00, `LST_IDX_TIMER_B, 2'b00};
   localparam logic [11:0] A_SD = {2'b00, `LST_IDX_SHUTDOWN, 2'b00};
   localparam logic [11:0] A_LO = {2'b00, `LST_IDX_SEL_LOW, 2'b00};
   localparam logic [11:0] A_HI = {2'b00, `LST_IDX_SEL_HIGH, 2'b00};
   logic        clk;
   logic        rst_n = 1'b0;
   logic        soft_reset = 1'b0;
   logic        restart_entry = 1'b0;
   logic        cyclic_sense = 1'b0;
   logic        supply_ov = 1'b0;
   logic        supply_uv = 1'b0;
   logic [3:0]  switch_fault = 4'h0;
   logic        first_timer = 1'b1;
   logic        first_pwm = 1'b0;
   logic        second_pwm = 1'b1;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic [3:0]  switch_output;
   logic        err;
   int          miscompares = 0;
   int          n_compared = 0;
   logic [11:0] adr [4] = '{A_TMR, A_SD, A_LO, A_HI};
   logic [7:0]  msk [4] = '{8'h77, 8'h70, 8'h77, 8'h77};
   logic [7:0]  sexp = 8'h26;

   lst_top #(.TIME_SCALE(200)) dut (.clk, .rst_n, .soft_reset,
      .restart_entry, .cyclic_sense, .supply_ov, .supply_uv, .switch_fault,
      .first_timer, .first_pwm, .second_pwm, .psel, .penable, .pwrite,
      .paddr, .pwdata, .prdata, .pready, .pslverr, .switch_output);

   // 200 MHz clock
   initial
   begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   // counts and verdict, then stop
   task automatic end_sim;
      $display("compared %0d mismatched %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   task automatic chk(input string s, input logic [31:0] e,
                      input logic [31:0] g);
      n_compared++;
      if (g !== e)
      begin
         $display("MISMATCH %s expected %h seen %h", s, e, g);
         miscompares++;
      end
   endtask

   // one apb transfer; data and error taken at the ready edge
   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [31:0] d, output logic [31:0] q);
      int n;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      do
      begin
         @(posedge clk);
         n++;
      end
      while (pready !== 1'b1 && n < 50);
      q = prdata;
      err = pslverr;
      if (pready !== 1'b1)
      begin
         miscompares++;
         end_sim();
      end
      else
      begin
         psel <= 1'b0;
         penable <= 1'b0;
         @(posedge clk);
      end
   endtask

   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      logic [31:0] q;
      apb(1'b1, a, {24'h0, d}, q);
   endtask

   task automatic rd(input logic [11:0] a, input logic [7:0] e);
      logic [31:0] q;
      apb(1'b0, a, 32'h0, q);
      chk("prdata", {24'h0, e}, q);
   endtask

   task automatic out_is(input int n, input logic [3:0] e);
      repeat (n) @(posedge clk);
      chk("switch_output", {28'h0, e}, {28'h0, switch_output});
   endtask

   // test sequence
   initial
   begin
      repeat (5) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      foreach (adr[i])
         rd(adr[i], 8'h00);
      foreach (adr[i])
      begin
         wr(adr[i], 8'hFF);
         rd(adr[i], msk[i]);
      end
      out_is(4, 4'h0);
      $display("end reserved");
      wr(A_TMR, 8'h00);
      for (int c = 0; c < 8; c++)
      begin
         wr(A_LO, {1'b0, 3'(c), 1'b0, 3'(c)});
         wr(A_HI, {1'b0, 3'(c), 1'b0, 3'(c)});
         out_is(4, {4{sexp[c]}});
      end
      $display("end select");
      wr(A_HI, 8'h00);
      wr(A_LO, 8'h03);
      wr(A_TMR, 8'h10);
      out_is(40, 4'h1);
      out_is(100, 4'h0);
      out_is(9900, 4'h1);
      wr(A_TMR, 8'h60);
      out_is(4, 4'h1);
      wr(A_TMR, 8'h70);
      out_is(4, 4'h0);
      wr(A_TMR, 8'h17);
      out_is(40, 4'h0);
      $display("end timer");
      wr(A_TMR, 8'h10);
      cyclic_sense <= 1'b1;
      restart_entry <= 1'b1;
      repeat (3) @(posedge clk);
      restart_entry <= 1'b0;
      rd(A_TMR, 8'h00);
      rd(A_LO, 8'h00);
      rd(A_SD, 8'h70);
      $display("end restart");
      wr(A_SD, 8'h00);
      wr(A_LO, 8'h11);
      wr(A_HI, 8'h11);
      supply_ov <= 1'b1;
      out_is(4, 4'h0);
      supply_ov <= 1'b0;
      out_is(4, 4'h0);
      wr(A_SD, 8'h10);
      wr(A_LO, 8'h11);
      wr(A_HI, 8'h11);
      out_is(4, 4'hF);
      supply_uv <= 1'b1;
      out_is(4, 4'h0);
      supply_uv <= 1'b0;
      out_is(4, 4'hF);
      wr(A_SD, 8'h60);
      supply_ov <= 1'b1;
      supply_uv <= 1'b1;
      out_is(4, 4'hF);
      supply_ov <= 1'b0;
      supply_uv <= 1'b0;
      $display("end supply");
      switch_fault <= 4'h9;
      repeat (3) @(posedge clk);
      switch_fault <= 4'h0;
      rd(A_LO, 8'h10);
      rd(A_HI, 8'h01);
      soft_reset <= 1'b1;
      repeat (3) @(posedge clk);
      soft_reset <= 1'b0;
      foreach (adr[i])
         rd(adr[i], 8'h00);
      rd(12'h044, 8'h00);
      chk("pslverr", 32'h1, {31'h0, err});
      $display("end fault and soft reset");
      end_sim();
   end
endmodule
